// ---- ltc_ctrl.sv ----
// Purpose: user-side controller for directed link changes and hot reset
// Assumes: device pins are asynchronous to sys_clk_in
// Notes: timeout abandons a change that never completes
`timescale 1ns/10ps
// Notes on behaviour
// - reason bit held with each request
// - request code selects width, speed, both
// - request only while link is up
// - root port speed needs auto attribute 11
// - target speed 0 slow, 1 fast
// - fast speed only when gen2 capable
// - target width 00, 10, 11 only
// - endpoint preferred de-emphasis drives 5.0 rate
// - de-emphasis updated with speed request
// - root port sends hot reset while held
module ltc_ctrl
  import ltc_pkg::*;
#(
  parameter int DONE_TMO_CYC = LTC_DONE_TMO_CYC
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // user orders
  input wire logic cmd_start_in,
  input wire logic [1:0] cmd_change_in,
  input wire logic cmd_speed_in,
  input wire logic [1:0] cmd_width_in,
  input wire logic cmd_auton_in,
  input wire logic cmd_deemph_in,
  input wire logic cmd_hot_reset_in,
  input wire logic cmd_deemph_src_in,
  input wire logic is_root_port_in,
  input wire logic [1:0] rp_auto_speed_attr_in,
  // user status
  output logic busy_out,
  output logic done_out,
  output logic error_out,
  output logic link_up_out,
  output logic [5:0] training_state_out,
  output logic [1:0] rx_power_state_out,
  output logic [2:0] tx_power_state_out,
  output logic [1:0] current_width_out,
  output logic hot_reset_seen_out,
  output logic bad_status_out,
  // device inputs
  input wire logic link_up_in,
  input wire logic second_gen_capable_in,
  input wire logic change_done_in,
  input wire logic inband_reset_received_in,
  input wire logic [5:0] training_state_code_in,
  input wire logic [1:0] rx_power_state_in,
  input wire logic [2:0] tx_power_state_in,
  input wire logic [1:0] current_width_code_in,
  // device outputs
  output logic [1:0] change_request_code_out,
  output logic target_speed_sel_out,
  output logic [1:0] target_width_code_out,
  output logic change_reason_autonomous_out,
  output logic ep_preferred_deemphasis_out,
  output logic inband_reset_send_out,
  output logic rp_deemphasis_source_out
);
  ltc_sync_if sy ();
  ltc_state_t state;
  ltc_state_t next_state;
  logic [31:0] tmo;

  ltc_sync u_sync
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .raw_in({link_up_in, second_gen_capable_in, change_done_in, inband_reset_received_in,
      training_state_code_in, rx_power_state_in, tx_power_state_in, current_width_code_in}),
    .sync_out(sy)
  );

  function automatic logic width_ok(input logic [1:0] w);
    width_ok = (w == LTC_WIDTH_X1) || (w == LTC_WIDTH_X4) || (w == LTC_WIDTH_X8);
  endfunction

  // ******************************
  // request admission
  // ******************************
  wire has_speed = cmd_change_in[1];
  wire has_width = cmd_change_in[0];
  wire speed_ok = !has_speed || !cmd_speed_in || sy.gen2_cap;
  wire rp_ok = !is_root_port_in || !has_speed ||
    (rp_auto_speed_attr_in == LTC_AUTO_SPD_ON);
  wire w_ok = !has_width || width_ok(cmd_width_in);
  wire cmd_legal = (cmd_change_in != LTC_CHG_NONE) && sy.link_up && speed_ok && rp_ok &&
    w_ok;
  wire accept = (state == LTC_IDLE) && cmd_start_in && cmd_legal;
  wire reject = (state == LTC_IDLE) && cmd_start_in && !cmd_legal;
  wire timed_out = (tmo == 32'(DONE_TMO_CYC - 1));
  wire lost_link = !sy.link_up;
  wire status_bad = ((sy.state_code > LTC_ST_MAX) || (sy.state_code == LTC_ST_GAP) ||
    (sy.tx_pm > LTC_TX_PM_MAX)) && sy.link_up;

  // ******************************
  // sequencer
  // ******************************
  always_comb
  begin
    next_state = state;
    case (state)
      LTC_IDLE:
        if (accept)
          next_state = LTC_REQ;
      LTC_REQ:
        if (sy.change_done || timed_out || lost_link)
          next_state = LTC_RELEASE;
      LTC_RELEASE:
        if (!sy.change_done)
          next_state = LTC_IDLE;
      default:
        next_state = LTC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= LTC_IDLE;
      tmo <= 32'h0;
      change_request_code_out <= LTC_CHG_NONE;
      target_speed_sel_out <= 1'b0;
      target_width_code_out <= LTC_WIDTH_X1;
      change_reason_autonomous_out <= 1'b0;
      ep_preferred_deemphasis_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmo <= (state == LTC_REQ) ? tmo + 32'h1 : 32'h0;
      busy_out <= (next_state != LTC_IDLE);
      done_out <= (state == LTC_REQ) && sy.change_done;
      if (accept)
      begin
        change_request_code_out <= cmd_change_in;
        target_speed_sel_out <= cmd_speed_in;
        target_width_code_out <= cmd_width_in;
        change_reason_autonomous_out <= cmd_auton_in;
        ep_preferred_deemphasis_out <= cmd_deemph_in;
      end
      else if (next_state == LTC_RELEASE)
        change_request_code_out <= LTC_CHG_NONE;
      if (accept)
        error_out <= 1'b0;
      else if (reject || ((state == LTC_REQ) && !sy.change_done && (timed_out || lost_link)))
        error_out <= 1'b1;
    end
  end

  // ******************************
  // hot reset and status
  // ******************************
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      inband_reset_send_out <= 1'b0;
      rp_deemphasis_source_out <= 1'b0;
      hot_reset_seen_out <= 1'b0;
      link_up_out <= 1'b0;
      training_state_out <= 6'h0;
      rx_power_state_out <= 2'h0;
      tx_power_state_out <= 3'h0;
      current_width_out <= 2'h0;
      bad_status_out <= 1'b0;
    end
    else
    begin
      inband_reset_send_out <= is_root_port_in && cmd_hot_reset_in;
      rp_deemphasis_source_out <= cmd_deemph_src_in;
      hot_reset_seen_out <= !is_root_port_in && sy.hot_rst_rx;
      link_up_out <= sy.link_up;
      training_state_out <= sy.state_code;
      rx_power_state_out <= sy.rx_pm;
      tx_power_state_out <= sy.tx_pm;
      if (sy.link_up)
        current_width_out <= sy.width;
      bad_status_out <= status_bad;
    end
  end

  // ******************************
  // checks
  // ******************************
  a_req_needs_link: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(busy_out) |-> $past(sy.link_up)) else $error("request without link up");
  a_req_code_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == LTC_REQ) && $past(state == LTC_REQ) |-> $stable(change_request_code_out))
    else $error("request code changed mid change");
  a_release_none: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == LTC_RELEASE) |-> change_request_code_out == LTC_CHG_NONE)
    else $error("request not dropped after done");
  a_speed_gen2: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(busy_out) && change_request_code_out[1] && target_speed_sel_out |->
    $past(sy.gen2_cap)) else $error("fast speed without gen2");
  a_rp_auto_speed_attr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(busy_out) && $past(is_root_port_in) && change_request_code_out[1] |->
    $past(rp_auto_speed_attr_in) == LTC_AUTO_SPD_ON)
    else $error("root port speed change not allowed");
  a_width_legal: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(busy_out) && change_request_code_out[0] |-> width_ok(target_width_code_out))
    else $error("illegal target width");
  a_hot_reset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_root_port_in && cmd_hot_reset_in ##1 is_root_port_in |-> inband_reset_send_out)
    else $error("hot reset not driven");
  a_fields_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    accept |=> change_request_code_out == $past(cmd_change_in) &&
    change_reason_autonomous_out == $past(cmd_auton_in))
    else $error("request fields not latched");
endmodule

// ---- ltc_pkg.sv ----
// Purpose: shared constants for the link change controller
// Assumes: 125 MHz system clock
// Notes: codes follow the core's physical-layer sideband
package ltc_pkg;
  localparam logic [1:0] LTC_CHG_NONE = 2'h0;
  localparam logic [1:0] LTC_CHG_WIDTH = 2'h1;
  localparam logic [1:0] LTC_CHG_SPEED = 2'h2;
  localparam logic [1:0] LTC_CHG_BOTH = 2'h3;
  localparam logic [1:0] LTC_WIDTH_X1 = 2'h0;
  localparam logic [1:0] LTC_WIDTH_X4 = 2'h2;
  localparam logic [1:0] LTC_WIDTH_X8 = 2'h3;
  localparam logic [1:0] LTC_AUTO_SPD_ON = 2'h3;
  localparam logic [5:0] LTC_ST_HOT_RESET = 6'h21;
  localparam logic [5:0] LTC_ST_MAX = 6'h33;
  localparam logic [5:0] LTC_ST_GAP = 6'h32;
  localparam logic [2:0] LTC_TX_PM_MAX = 3'h3;
  localparam int LTC_CLK_MHZ = 125;
  localparam int LTC_DONE_TMO_US = 100;
  localparam int LTC_DONE_TMO_CYC = LTC_DONE_TMO_US * LTC_CLK_MHZ;
  typedef enum logic [1:0] {LTC_IDLE, LTC_REQ, LTC_RELEASE} ltc_state_t;
endpackage

// ---- ltc_sync_if.sv ----
// Purpose: bundle of synchronised device status
// Assumes: one clock
// Notes: carried between sync stage and controller
`timescale 1ns/10ps
interface ltc_sync_if;
  logic link_up;
  logic gen2_cap;
  logic change_done;
  logic hot_rst_rx;
  logic [5:0] state_code;
  logic [1:0] rx_pm;
  logic [2:0] tx_pm;
  logic [1:0] width;
  modport src (output link_up, gen2_cap, change_done, hot_rst_rx, state_code, rx_pm, tx_pm,
    width);
  modport dst (input link_up, gen2_cap, change_done, hot_rst_rx, state_code, rx_pm, tx_pm,
    width);
endinterface

// ---- ltc_sync.sv ----
// Purpose: two-flop synchroniser for device status pins
// Assumes: pins come from another timing domain
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module ltc_sync
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [16:0] raw_in,
  ltc_sync_if.src sync_out
);
  logic [16:0] meta;
  logic [16:0] stable;
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta <= 17'h0;
      stable <= 17'h0;
    end
    else
    begin
      meta <= raw_in;
      stable <= meta;
    end
  end
  assign {sync_out.link_up, sync_out.gen2_cap, sync_out.change_done, sync_out.hot_rst_rx,
    sync_out.state_code, sync_out.rx_pm, sync_out.tx_pm, sync_out.width} = stable;
endmodule

// ---- ltc_dev_model.sv ----
// Purpose: device-side model of the link sideband
// Assumes: bench sets link status through knob_in
// Notes: done rises DONE_DELAY+1 cycles after a request
`timescale 1ns/10ps
module ltc_dev_model
#(
  parameter int DONE_DELAY = 6
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // from controller
  input wire logic [1:0] req_in,
  input wire logic [1:0] width_in,
  input wire logic send_in,
  // link, gen2, hot rx, state, rx pm, tx pm
  input wire logic [13:0] knob_in,
  // to controller
  output logic link_out,
  output logic gen2_out,
  output logic done_out,
  output logic hot_rx_out,
  output logic [5:0] state_out,
  output logic [1:0] rx_out,
  output logic [2:0] tx_out,
  output logic [1:0] width_out
);
  logic [3:0] cnt;
  assign link_out = knob_in[13];
  assign gen2_out = knob_in[12];
  assign hot_rx_out = knob_in[11];
  assign state_out = send_in ? 6'h21 : knob_in[10:5];
  assign rx_out = knob_in[4:3];
  assign tx_out = knob_in[2:0];
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
    begin
      cnt <= 4'h0;
      done_out <= 1'b0;
      width_out <= 2'h0;
    end
    else if (req_in == 2'h0)
    begin
      cnt <= 4'h0;
      done_out <= 1'b0;
    end
    else if (cnt == 4'(DONE_DELAY))
    begin
      done_out <= 1'b1;
      if (req_in[0])
        width_out <= width_in;
    end
    else
      cnt <= cnt + 4'h1;
endmodule

// ---- test_link_training_control_status.sv ----
// Purpose: self-checking bench for the link change controller
// Assumes: device model answers every request
// Notes: knob layout is link, gen2, hot rx, state, rx pm, tx pm
`timescale 1ns/10ps
module test_link_training_control_status;
  import ltc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_start_in = 1'b0, cmd_speed_in = 1'b0, cmd_auton_in = 1'b0, cmd_deemph_in = 1'b0;
  logic cmd_hot_reset_in = 1'b0, cmd_deemph_src_in = 1'b0, is_root_port_in = 1'b0;
  logic [1:0] cmd_change_in = 2'h0, cmd_width_in = 2'h0, rp_auto_speed_attr_in = 2'h0;
  logic [13:0] knob = 14'h0;
  wire busy_out, done_out, error_out, link_up_out, hot_reset_seen_out, bad_status_out;
  wire [5:0] training_state_out, training_state_code_in;
  wire [1:0] rx_power_state_out, current_width_out, change_request_code_out;
  wire [2:0] tx_power_state_out, tx_power_state_in;
  wire [1:0] target_width_code_out, rx_power_state_in, current_width_code_in;
  wire target_speed_sel_out, change_reason_autonomous_out, ep_preferred_deemphasis_out;
  wire inband_reset_send_out, rp_deemphasis_source_out, link_up_in, second_gen_capable_in;
  wire change_done_in, inband_reset_received_in;
  int num_errors = 0;
  int checked = 0;
  logic [5:0] st_list [9] = '{6'h1e, 6'h21, 6'h25, 6'h26, 6'h2c, 6'h2d, 6'h2e, 6'h31, 6'h33};
  always #4 sys_clk_in = ~sys_clk_in;
  ltc_ctrl #(.DONE_TMO_CYC(50)) u_dut (.sys_clk_in, .rst_in, .cmd_start_in, .cmd_change_in,
    .cmd_speed_in, .cmd_width_in, .cmd_auton_in, .cmd_deemph_in, .cmd_hot_reset_in,
    .cmd_deemph_src_in, .is_root_port_in, .rp_auto_speed_attr_in, .busy_out, .done_out,
    .error_out, .link_up_out, .training_state_out, .rx_power_state_out, .tx_power_state_out,
    .current_width_out, .hot_reset_seen_out, .bad_status_out, .link_up_in,
    .second_gen_capable_in, .change_done_in, .inband_reset_received_in,
    .training_state_code_in, .rx_power_state_in, .tx_power_state_in, .current_width_code_in,
    .change_request_code_out, .target_speed_sel_out, .target_width_code_out,
    .change_reason_autonomous_out, .ep_preferred_deemphasis_out, .inband_reset_send_out,
    .rp_deemphasis_source_out);
  ltc_dev_model u_dev (.sys_clk_in, .rst_in, .req_in(change_request_code_out),
    .width_in(target_width_code_out), .send_in(inband_reset_send_out), .knob_in(knob),
    .link_out(link_up_in), .gen2_out(second_gen_capable_in), .done_out(change_done_in),
    .hot_rx_out(inband_reset_received_in), .state_out(training_state_code_in),
    .rx_out(rx_power_state_in), .tx_out(tx_power_state_in), .width_out(current_width_code_in));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic set_knob(input logic [13:0] v);
    @(posedge sys_clk_in);
    knob <= v;
    cyc(4);
  endtask
  task automatic order(input logic [1:0] c, input logic s, input logic [1:0] w, input logic a);
    @(posedge sys_clk_in);
    cmd_change_in <= c;
    cmd_speed_in <= s;
    cmd_width_in <= w;
    cmd_auton_in <= a;
    cmd_start_in <= 1'b1;
    @(posedge sys_clk_in);
    cmd_start_in <= 1'b0;
    #1;
  endtask
  task automatic t_change(input logic [1:0] c, input logic s, input logic [1:0] w, input logic a);
    order(c, s, w, a);
    chk("request", 8'(c), 8'(change_request_code_out));
    chk("speed", 8'(s), 8'(target_speed_sel_out));
    chk("width", 8'(w), 8'(target_width_code_out));
    chk("reason", 8'(a), 8'(change_reason_autonomous_out));
    chk("deemph", 8'(cmd_deemph_in), 8'(ep_preferred_deemphasis_out));
    chk("busy", 8'h1, 8'(busy_out));
    repeat (40) if (done_out !== 1'b1) cyc(1);
    chk("done", 8'h1, 8'(done_out));
    chk("request off", 8'h0, 8'(change_request_code_out));
    repeat (30) if (busy_out !== 1'b0) cyc(1);
    chk("idle", 8'h0, 8'(busy_out));
    chk("error", 8'h0, 8'(error_out));
    if (c[0])
      chk("new width", 8'(w), 8'(current_width_out));
  endtask
  task automatic t_reject(input logic [1:0] c, input logic s, input logic [1:0] w);
    order(c, s, w, 1'b0);
    chk("reject error", 8'h1, 8'(error_out));
    chk("reject request", 8'h0, 8'(change_request_code_out));
  endtask
  task automatic t_lost;
    order(LTC_CHG_WIDTH, 1'b0, LTC_WIDTH_X4, 1'b0);
    @(posedge sys_clk_in);
    knob <= {3'h0, 6'h16, 5'h0};
    cyc(8);
    chk("lost error", 8'h1, 8'(error_out));
    chk("lost request", 8'h0, 8'(change_request_code_out));
    chk("lost idle", 8'h0, 8'(busy_out));
  endtask
  task automatic t_status(input logic [5:0] st, input logic [1:0] rx, input logic [2:0] tx);
    set_knob({3'h6, st, rx, tx});
    chk("state", 8'(st), 8'(training_state_out));
    chk("rx pm", 8'(rx), 8'(rx_power_state_out));
    chk("tx pm", 8'(tx), 8'(tx_power_state_out));
    chk("link up", 8'h1, 8'(link_up_out));
    chk("good status", 8'h0, 8'(bad_status_out));
  endtask
  task automatic test_done;
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    cyc(1);
    chk("reset request", 8'h0, 8'(change_request_code_out));
    set_knob({3'h6, 6'h16, 5'h0});
    t_change(LTC_CHG_WIDTH, 1'b0, LTC_WIDTH_X4, 1'b0);
    t_change(LTC_CHG_WIDTH, 1'b0, LTC_WIDTH_X8, 1'b1);
    @(posedge sys_clk_in);
    cmd_deemph_in <= 1'b1;
    t_change(LTC_CHG_SPEED, 1'b1, LTC_WIDTH_X1, 1'b1);
    t_change(LTC_CHG_BOTH, 1'b1, LTC_WIDTH_X1, 1'b0);
    t_reject(LTC_CHG_WIDTH, 1'b0, 2'h1);
    set_knob({3'h4, 6'h16, 5'h0});
    t_reject(LTC_CHG_SPEED, 1'b1, 2'h0);
    t_change(LTC_CHG_SPEED, 1'b0, 2'h0, 1'b0);
    @(posedge sys_clk_in);
    is_root_port_in <= 1'b1;
    rp_auto_speed_attr_in <= 2'h2;
    t_reject(LTC_CHG_SPEED, 1'b0, 2'h0);
    @(posedge sys_clk_in);
    rp_auto_speed_attr_in <= LTC_AUTO_SPD_ON;
    t_change(LTC_CHG_SPEED, 1'b0, 2'h0, 1'b0);
    t_lost;
    set_knob({3'h0, 6'h16, 5'h0});
    chk("link down", 8'h0, 8'(link_up_out));
    t_reject(LTC_CHG_WIDTH, 1'b0, 2'h0);
    foreach (st_list[i])
      t_status(st_list[i], 2'(i), 3'(i % 4));
    set_knob({3'h6, 6'h32, 5'h0});
    chk("bad state", 8'h1, 8'(bad_status_out));
    set_knob({3'h6, 6'h16, 5'h4});
    chk("bad tx pm", 8'h1, 8'(bad_status_out));
    @(posedge sys_clk_in);
    cmd_hot_reset_in <= 1'b1;
    cmd_deemph_src_in <= 1'b1;
    cyc(1);
    chk("hot send", 8'h1, 8'(inband_reset_send_out));
    chk("deemph source", 8'h1, 8'(rp_deemphasis_source_out));
    cyc(4);
    chk("hot state", 8'h21, 8'(training_state_out));
    @(posedge sys_clk_in);
    is_root_port_in <= 1'b0;
    cyc(1);
    chk("endpoint send", 8'h0, 8'(inband_reset_send_out));
    set_knob({3'h7, 6'h16, 5'h0});
    chk("hot seen", 8'h1, 8'(hot_reset_seen_out));
    test_done;
  end
endmodule
